/* File: secc_defines.vh */
// Constants for the status event common command block
`ifndef SECC_DEFINES_VH
`define SECC_DEFINES_VH

// Command codes on the command port
`define SECC_CMD_W          3
`define SECC_CMD_CLS        3'h1
`define SECC_CMD_ESE_SET    3'h2
`define SECC_CMD_ESE_QRY    3'h3
`define SECC_CMD_ESR_QRY    3'h4
`define SECC_CMD_OPC        3'h5

// Standard event register bit positions
`define SECC_EVT_W          8
`define SECC_BIT_OPC        0
`define SECC_BIT_CME        5

// Reset values
`define SECC_MASK_RST       8'h00
`define SECC_EVT_RST        8'h00

// Interrupt status bits
`define SECC_INT_W          3
`define SECC_INT_ESB        0
`define SECC_INT_RESP       1
`define SECC_INT_CME        2

// Register byte offsets
`define SECC_ADDR_W         8
`define SECC_OFF_EVT        8'h00
`define SECC_OFF_ENABLE     8'h04
`define SECC_OFF_INT_STAT   8'h08
`define SECC_OFF_INT_MASK   8'h0C
`define SECC_OFF_SUMMARY    8'h10

// Bus responses
`define SECC_RESP_OKAY      2'h0
`define SECC_RESP_SLVERR    2'h2

`endif

/* File: secc_evt_reg.v */
// Sticky event bits where a set in the same cycle beats a clear
module secc_evt_reg #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         i_core_clk,
   input  wire         i_rst,
   // Event control
   input  wire [W-1:0] i_set,
   input  wire [W-1:0] i_clr,
   // State
   output reg  [W-1:0] o_q
);

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_q <= {W{1'b0}};
      end else begin
         o_q <= (o_q & ~i_clr) | i_set;
      end
   end

endmodule // secc_evt_reg

/* File: secc_top.v */
// Status event common commands: clear, event enable, event status, summary
//
// Functional notes
// - Clear status empties event, extended, error queue
// - Clear status first in message flushes output
// - Enable set loads 8-bit mask, query returns it
// - Masked event bit never raises summary bit
// - Enable mask is zero after reset
// - Enable query leaves the mask unchanged
// - Event query returns register then clears it
// - Syntax error sets event bit 5
// - Bit 0 set by operation complete command
`include "secc_defines.vh"

module secc_top #(
   parameter EVT_W = `SECC_EVT_W,
   parameter INT_W = `SECC_INT_W
) (
   // Clock and reset
   input  wire                    i_core_clk,
   input  wire                    i_rst,
   // Command port
   input  wire                    i_cmd_valid,
   input  wire [`SECC_CMD_W-1:0]  i_cmd_code,
   input  wire [EVT_W-1:0]        i_cmd_arg,
   input  wire                    i_cmd_first,
   // Event sources
   input  wire [EVT_W-1:0]        i_evt_set,
   // Query answer
   output reg                     o_resp_valid,
   output reg  [EVT_W-1:0]        o_resp_data,
   // Clear strobes and status
   output reg                     o_err_queue_clr,
   output reg                     o_ext_evt_clr,
   output reg                     o_out_queue_clr,
   output reg                     o_event_summary_bit,
   output reg                     o_irq,
   // AXI4-Lite write address
   input  wire                    i_s_axi_awvalid,
   output reg                     o_s_axi_awready,
   input  wire [`SECC_ADDR_W-1:0] i_s_axi_awaddr,
   // AXI4-Lite write data
   input  wire                    i_s_axi_wvalid,
   output reg                     o_s_axi_wready,
   input  wire [31:0]             i_s_axi_wdata,
   input  wire [3:0]              i_s_axi_wstrb,
   // AXI4-Lite write response
   output reg                     o_s_axi_bvalid,
   input  wire                    i_s_axi_bready,
   output reg  [1:0]              o_s_axi_bresp,
   // AXI4-Lite read address
   input  wire                    i_s_axi_arvalid,
   output reg                     o_s_axi_arready,
   input  wire [`SECC_ADDR_W-1:0] i_s_axi_araddr,
   // AXI4-Lite read data
   output reg                     o_s_axi_rvalid,
   input  wire                    i_s_axi_rready,
   output reg  [31:0]             o_s_axi_rdata,
   output reg  [1:0]              o_s_axi_rresp
);

   localparam [1:0] RD_IDLE = 2'b01;
   localparam [1:0] RD_DATA = 2'b10;

   // Single-bit vector at a given position
   function [EVT_W-1:0] evt_bit;
      input integer pos;
      begin
         evt_bit = {EVT_W{1'b0}};
         evt_bit[pos] = 1'b1;
      end
   endfunction

   // Known register offset
   function addr_mapped;
      input [`SECC_ADDR_W-1:0] a;
      begin
         addr_mapped = (a == `SECC_OFF_EVT) || (a == `SECC_OFF_ENABLE) ||
                       (a == `SECC_OFF_INT_STAT) || (a == `SECC_OFF_INT_MASK) ||
                       (a == `SECC_OFF_SUMMARY);
      end
   endfunction

   reg  [EVT_W-1:0]        mask_r;
   reg  [INT_W-1:0]        int_mask_r;
   reg                     aw_got_r;
   reg                     w_got_r;
   reg  [`SECC_ADDR_W-1:0] waddr_r;
   reg  [31:0]             wdata_r;
   reg  [3:0]              wstrb_r;
   reg  [1:0]              rd_state_r;
   wire [EVT_W-1:0]        evt_q;
   wire [INT_W-1:0]        int_q;

   // Command decode
   wire cmd_cls     = i_cmd_valid && (i_cmd_code == `SECC_CMD_CLS);
   wire cmd_ese_set = i_cmd_valid && (i_cmd_code == `SECC_CMD_ESE_SET);
   wire cmd_ese_qry = i_cmd_valid && (i_cmd_code == `SECC_CMD_ESE_QRY);
   wire cmd_esr_qry = i_cmd_valid && (i_cmd_code == `SECC_CMD_ESR_QRY);
   wire cmd_opc     = i_cmd_valid && (i_cmd_code == `SECC_CMD_OPC);
   wire cmd_bad     = i_cmd_valid && !(cmd_cls || cmd_ese_set || cmd_ese_qry ||
                                       cmd_esr_qry || cmd_opc);

   // Standard event register
   wire [EVT_W-1:0] evt_set =
      i_evt_set |
      (cmd_opc ? evt_bit(`SECC_BIT_OPC) : {EVT_W{1'b0}}) |
      (cmd_bad ? evt_bit(`SECC_BIT_CME) : {EVT_W{1'b0}});
   // Fresh events in the clearing cycle survive the clear
   wire [EVT_W-1:0] evt_clr = {EVT_W{cmd_cls || cmd_esr_qry}};

   secc_evt_reg #(
      .W (EVT_W)
   ) u_std_evt (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_set      (evt_set),
      .i_clr      (evt_clr),
      .o_q        (evt_q)
   );

   // Write path
   wire wr_fire = aw_got_r && w_got_r && !o_s_axi_bvalid;
   wire wr_ok   = addr_mapped(waddr_r);
   wire wr_low  = wr_fire && wr_ok && wstrb_r[0];

   // Bus write to the enable register, command port wins a collision
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mask_r <= `SECC_MASK_RST;
      end else if (cmd_ese_set) begin
         mask_r <= i_cmd_arg;
      end else if (wr_low && (waddr_r == `SECC_OFF_ENABLE)) begin
         mask_r <= wdata_r[EVT_W-1:0];
      end
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         int_mask_r <= {INT_W{1'b0}};
      end else if (wr_low && (waddr_r == `SECC_OFF_INT_MASK)) begin
         int_mask_r <= wdata_r[INT_W-1:0];
      end
   end

   // Summary, query answers and clear strobes
   wire summary_nxt = |(evt_q & mask_r);

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event_summary_bit <= 1'b0;
         o_resp_valid        <= 1'b0;
         o_resp_data         <= {EVT_W{1'b0}};
         o_err_queue_clr     <= 1'b0;
         o_ext_evt_clr       <= 1'b0;
         o_out_queue_clr     <= 1'b0;
      end else begin
         o_event_summary_bit <= summary_nxt;
         o_resp_valid        <= cmd_ese_qry || cmd_esr_qry;
         if (cmd_ese_qry) begin
            o_resp_data <= mask_r;
         end else if (cmd_esr_qry) begin
            o_resp_data <= evt_q;
         end
         o_err_queue_clr <= cmd_cls;
         o_ext_evt_clr   <= cmd_cls;
         o_out_queue_clr <= cmd_cls && i_cmd_first;
      end
   end

   // Interrupt status: summary rise, query answer, syntax error
   wire [INT_W-1:0] int_set;
   assign int_set[`SECC_INT_ESB]  = summary_nxt && !o_event_summary_bit;
   assign int_set[`SECC_INT_RESP] = cmd_ese_qry || cmd_esr_qry;
   assign int_set[`SECC_INT_CME]  = cmd_bad;
   wire [INT_W-1:0] int_clr =
      (wr_low && (waddr_r == `SECC_OFF_INT_STAT)) ? wdata_r[INT_W-1:0] : {INT_W{1'b0}};

   secc_evt_reg #(
      .W (INT_W)
   ) u_int_stat (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_set      (int_set),
      .i_clr      (int_clr),
      .o_q        (int_q)
   );

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(int_q & int_mask_r);
      end
   end

   // Write channels: address and data taken in either order
   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_got_r        <= 1'b0;
         w_got_r         <= 1'b0;
         waddr_r         <= {`SECC_ADDR_W{1'b0}};
         wdata_r         <= 32'h00000000;
         wstrb_r         <= 4'h0;
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready  <= 1'b0;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= `SECC_RESP_OKAY;
      end else begin
         if (o_s_axi_bvalid) begin
            if (i_s_axi_bready) begin
               o_s_axi_bvalid  <= 1'b0;
               aw_got_r        <= 1'b0;
               w_got_r         <= 1'b0;
               o_s_axi_awready <= 1'b1;
               o_s_axi_wready  <= 1'b1;
            end
         end else begin
            if (!aw_got_r) begin
               o_s_axi_awready <= 1'b1;
            end
            if (!w_got_r) begin
               o_s_axi_wready <= 1'b1;
            end
            if (o_s_axi_awready && i_s_axi_awvalid) begin
               aw_got_r        <= 1'b1;
               waddr_r         <= i_s_axi_awaddr;
               o_s_axi_awready <= 1'b0;
            end
            if (o_s_axi_wready && i_s_axi_wvalid) begin
               w_got_r        <= 1'b1;
               wdata_r        <= i_s_axi_wdata;
               wstrb_r        <= i_s_axi_wstrb;
               o_s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
               o_s_axi_bvalid <= 1'b1;
               o_s_axi_bresp  <= wr_ok ? `SECC_RESP_OKAY : `SECC_RESP_SLVERR;
            end
         end
      end
   end

   // Read mux; reading never disturbs the event register
   reg [31:0] rd_word;
   always @* begin
      rd_word = 32'h00000000;
      case (i_s_axi_araddr)
         `SECC_OFF_EVT:      rd_word[EVT_W-1:0] = evt_q;
         `SECC_OFF_ENABLE:   rd_word[EVT_W-1:0] = mask_r;
         `SECC_OFF_INT_STAT: rd_word[INT_W-1:0] = int_q;
         `SECC_OFF_INT_MASK: rd_word[INT_W-1:0] = int_mask_r;
         `SECC_OFF_SUMMARY:  rd_word[0]         = o_event_summary_bit;
         default:            rd_word            = 32'h00000000;
      endcase
   end

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_state_r      <= RD_IDLE;
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h00000000;
         o_s_axi_rresp   <= `SECC_RESP_OKAY;
      end else begin
         case (rd_state_r)
            RD_IDLE: begin
               o_s_axi_arready <= 1'b1;
               if (o_s_axi_arready && i_s_axi_arvalid) begin
                  o_s_axi_arready <= 1'b0;
                  o_s_axi_rvalid  <= 1'b1;
                  o_s_axi_rdata   <= rd_word;
                  o_s_axi_rresp   <= addr_mapped(i_s_axi_araddr) ?
                                     `SECC_RESP_OKAY : `SECC_RESP_SLVERR;
                  rd_state_r      <= RD_DATA;
               end
            end
            RD_DATA: begin
               if (i_s_axi_rready) begin
                  o_s_axi_rvalid  <= 1'b0;
                  o_s_axi_arready <= 1'b1;
                  rd_state_r      <= RD_IDLE;
               end
            end
            default: begin
               rd_state_r      <= RD_IDLE;
               o_s_axi_rvalid  <= 1'b0;
               o_s_axi_arready <= 1'b0;
            end
         endcase
      end
   end

endmodule // secc_top

/* File: secc_top_asserts.sv */
// Checker for command answers, clear strobes and the summary bit
`include "secc_defines.vh"
module secc_top_asserts #(
   parameter EVT_W = 8
) (
   // Clock and reset
   input wire             i_core_clk,
   input wire             i_rst,
   // Command port and events
   input wire             i_cmd_valid,
   input wire [2:0]       i_cmd_code,
   input wire [EVT_W-1:0] i_cmd_arg,
   input wire             i_cmd_first,
   input wire [EVT_W-1:0] i_evt_set,
   // Watched outputs
   input wire             o_resp_valid,
   input wire [EVT_W-1:0] o_resp_data,
   input wire             o_err_queue_clr,
   input wire             o_ext_evt_clr,
   input wire             o_out_queue_clr,
   input wire             o_event_summary_bit
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   wire cls = i_cmd_valid && i_cmd_code == `SECC_CMD_CLS;
   wire ese = i_cmd_valid && i_cmd_code == `SECC_CMD_ESE_SET;
   wire eq  = i_cmd_valid && i_cmd_code == `SECC_CMD_ESE_QRY;
   wire esr = i_cmd_valid && i_cmd_code == `SECC_CMD_ESR_QRY;
   wire operation_complete_flag = i_cmd_valid && i_cmd_code == `SECC_CMD_OPC;
   wire bad = i_cmd_valid && i_cmd_code == 3'h0;

   AST_CLS_STROBE: assert property (cls |=> o_err_queue_clr && o_ext_evt_clr)
      else $error("clear status strobes missing");
   AST_OUTQ_FLUSH: assert property (cls && i_cmd_first |=> o_out_queue_clr)
      else $error("output queue flush missing");
   AST_OUTQ_HOLD: assert property (cls && !i_cmd_first |=> !o_out_queue_clr)
      else $error("output queue flushed mid message");
   AST_ESE_ECHO: assert property (ese ##1 eq |=> o_resp_data == $past(i_cmd_arg, 2))
      else $error("enable query differs from value set");
   AST_ESE_KEEP: assert property (eq ##1 eq |=> o_resp_data == $past(o_resp_data))
      else $error("enable query changed the mask");
   AST_RST_MASK: assert property ($fell(i_rst) |-> !o_event_summary_bit [*3])
      else $error("summary set after reset");
   AST_ESR_CLEAR: assert property (esr && i_evt_set == 0 ##1 esr |=> o_resp_data == 0)
      else $error("event query did not clear");
   AST_SYNTAX_BIT: assert property (bad ##1 esr |=> o_resp_data[`SECC_BIT_CME])
      else $error("syntax error bit not set");
   AST_OPC_BIT: assert property (operation_complete_flag ##1 esr |=> o_resp_data[`SECC_BIT_OPC])
      else $error("operation complete bit not set");
   AST_MASKED: assert property ((ese && i_cmd_arg == 8'hFB) ##1 (esr && i_evt_set == 0)
      ##1 (!i_cmd_valid && i_evt_set == 0) ##1 (!i_cmd_valid && i_evt_set == 8'h04)
      ##1 !i_cmd_valid |=> !o_event_summary_bit) else $error("masked bit raised summary");
   AST_SUM_DROP: assert property (esr && i_evt_set == 0 ##1 !i_cmd_valid && i_evt_set == 0
      |=> !o_event_summary_bit) else $error("summary set with empty register");

   CV_FLUSH: cover property (cls && i_cmd_first);
   CV_SUM: cover property ($rose(o_event_summary_bit));
   CV_ECHO: cover property (ese ##1 eq);
endmodule // secc_top_asserts

bind secc_top secc_top_asserts #(.EVT_W(EVT_W)) secc_top_asserts_inst (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
   .i_cmd_code(i_cmd_code), .i_cmd_arg(i_cmd_arg), .i_cmd_first(i_cmd_first),
   .i_evt_set(i_evt_set), .o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data),
   .o_err_queue_clr(o_err_queue_clr), .o_ext_evt_clr(o_ext_evt_clr),
   .o_out_queue_clr(o_out_queue_clr), .o_event_summary_bit(o_event_summary_bit));

/* File: secc_ctrl_model.sv */
// Remote controller model that issues common commands
module secc_ctrl_model (
   // Clock
   input  wire        i_core_clk,
   // Command port
   output logic       o_cmd_valid,
   output logic [2:0] o_cmd_code,
   output logic [7:0] o_cmd_arg,
   output logic       o_cmd_first
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code  = 3'h0;
      o_cmd_arg   = 8'h00;
      o_cmd_first = 1'b0;
   end
   // Keep set holds valid so the next call goes back to back
   task issue(input [2:0] code, input [7:0] arg, input first, input keep);
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_code  <= code;
      o_cmd_arg   <= arg;
      o_cmd_first <= first;
      if (!keep) begin
         @(posedge i_core_clk);
         o_cmd_valid <= 1'b0;
         o_cmd_arg   <= ~arg;
         o_cmd_first <= ~first;
         #1;
      end
   endtask
endmodule // secc_ctrl_model

/* File: secc_top_tb_top.sv */
// Self-checking bench for the status event command block
`include "secc_defines.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module secc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk, i_rst, i_cmd_valid, i_cmd_first, i_s_axi_awvalid, i_s_axi_wvalid;
   logic i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready, o_resp_valid, o_err_queue_clr;
   logic o_ext_evt_clr, o_out_queue_clr, o_event_summary_bit, o_irq, o_s_axi_awready;
   logic o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [2:0] i_cmd_code;
   logic [3:0] i_s_axi_wstrb;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic [7:0] i_cmd_arg, i_evt_set, i_s_axi_awaddr, i_s_axi_araddr, o_resp_data;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic [7:0] vals [4] = '{8'h00, 8'hFB, 8'hFF, 8'h80};
   logic [2:0] bads [3] = '{3'h0, 3'h6, 3'h7};
   int fails = 0;
   int n_checks = 0;

   secc_top secc_top_inst (.*);
   secc_ctrl_model secc_ctrl_model_inst (.i_core_clk(i_core_clk), .o_cmd_valid(i_cmd_valid),
      .o_cmd_code(i_cmd_code), .o_cmd_arg(i_cmd_arg), .o_cmd_first(i_cmd_first));

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   task final_report;
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cmd(input [2:0] c, input [7:0] a, input f, input k);
      secc_ctrl_model_inst.issue(c, a, f, k);
   endtask
   task qry(input [2:0] c, input [7:0] e);
      cmd(c, 8'h00, 1'b0, 1'b0);
      `CHK(o_resp_valid, 1'b1)
      `CHK(o_resp_data, e)
   endtask
   // Handshakes sampled mid-cycle: slave outputs only move on the rising edge
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      logic aw_t, w_t, b_t;
      logic [1:0] resp;
      b_t = 1'b0;
      @(posedge i_core_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      while (!b_t) begin
         @(negedge i_core_clk);
         aw_t = i_s_axi_awvalid && o_s_axi_awready;
         w_t  = i_s_axi_wvalid && o_s_axi_wready;
         b_t  = o_s_axi_bvalid;
         resp = o_s_axi_bresp;
         @(posedge i_core_clk);
         if (aw_t) i_s_axi_awvalid <= 1'b0;
         if (w_t) i_s_axi_wvalid <= 1'b0;
      end
      i_s_axi_bready <= 1'b0;
      `CHK(resp, er)
   endtask
   task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
      logic ar_t, r_t;
      logic [31:0] data;
      logic [1:0] resp;
      r_t = 1'b0;
      @(posedge i_core_clk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      while (!r_t) begin
         @(negedge i_core_clk);
         ar_t = i_s_axi_arvalid && o_s_axi_arready;
         r_t  = o_s_axi_rvalid;
         data = o_s_axi_rdata;
         resp = o_s_axi_rresp;
         @(posedge i_core_clk);
         if (ar_t) i_s_axi_arvalid <= 1'b0;
      end
      i_s_axi_rready <= 1'b0;
      `CHK(data, ed)
      `CHK(resp, er)
   endtask
   task settle(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask

   initial begin
      i_rst = 1'b1;
      i_evt_set = 8'h00;
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
      i_s_axi_wstrb = 4'hF;
      repeat (20) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      rd(`SECC_OFF_ENABLE, 32'h0, `SECC_RESP_OKAY);
      qry(`SECC_CMD_ESE_QRY, 8'h00);
      rd(8'h14, 32'h0, `SECC_RESP_SLVERR);
      wr(8'h14, 32'h1, `SECC_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         cmd(`SECC_CMD_ESE_SET, vals[i], 1'b0, 1'b1);
         cmd(`SECC_CMD_ESE_QRY, 8'h00, 1'b0, 1'b1);
         qry(`SECC_CMD_ESE_QRY, vals[i]);
         rd(`SECC_OFF_ENABLE, {24'h0, vals[i]}, `SECC_RESP_OKAY);
      end
      for (int i = 0; i < 3; i++) begin
         cmd(bads[i], 8'h00, 1'b0, 1'b1);
         qry(`SECC_CMD_ESR_QRY, 8'h20);
      end
      cmd(`SECC_CMD_ESR_QRY, 8'h00, 1'b0, 1'b1);
      qry(`SECC_CMD_ESR_QRY, 8'h00);
      cmd(`SECC_CMD_OPC, 8'h00, 1'b0, 1'b1);
      qry(`SECC_CMD_ESR_QRY, 8'h01);
      cmd(`SECC_CMD_ESE_SET, 8'hFB, 1'b0, 1'b1);
      cmd(`SECC_CMD_ESR_QRY, 8'h00, 1'b0, 1'b0);
      @(posedge i_core_clk) i_evt_set <= 8'h04;
      @(posedge i_core_clk) i_evt_set <= 8'h00;
      settle(2);
      `CHK(o_event_summary_bit, 1'b0)
      @(posedge i_core_clk) i_evt_set <= 8'h20;
      @(posedge i_core_clk) i_evt_set <= 8'h00;
      settle(2);
      `CHK(o_event_summary_bit, 1'b1)
      wr(`SECC_OFF_INT_MASK, 32'h4, `SECC_RESP_OKAY);
      rd(`SECC_OFF_INT_STAT, 32'h7, `SECC_RESP_OKAY);
      `CHK(o_irq, 1'b1)
      wr(`SECC_OFF_INT_STAT, 32'h4, `SECC_RESP_OKAY);
      settle(2);
      `CHK(o_irq, 1'b0)
      cmd(3'h7, 8'h00, 1'b0, 1'b0);
      settle(2);
      `CHK(o_irq, 1'b1)
      wr(`SECC_OFF_INT_MASK, 32'h0, `SECC_RESP_OKAY);
      settle(2);
      `CHK(o_irq, 1'b0)
      cmd(`SECC_CMD_CLS, 8'h00, 1'b0, 1'b0);
      `CHK({o_err_queue_clr, o_ext_evt_clr, o_out_queue_clr}, 3'h6)
      rd(`SECC_OFF_EVT, 32'h0, `SECC_RESP_OKAY);
      cmd(`SECC_CMD_CLS, 8'h00, 1'b1, 1'b0);
      `CHK(o_out_queue_clr, 1'b1)
      `CHK(o_event_summary_bit, 1'b0)
      final_report;
   end

   // Whole sequence needs well under 1000 cycles
   initial begin
      repeat (4000) @(posedge i_core_clk);
      fails++;
      final_report;
   end
endmodule // secc_top_tb_top
